// ===== fsync_sel_pkg.sv
// Shared constants for the frame-sync input selector.
// Assumes a single 40 MHz master clock and no software register bus.
`default_nettype none

package fsync_sel_pkg;

    // ********************************************************************
    // Source field decode
    // ********************************************************************
    localparam logic [3:0] SRC_PAIR_MASK = 4'hc;
    localparam logic [3:0] SRC_PAIR_CODE = 4'hc;
    localparam logic [1:0] PAIR_AUTO = 2'h0;
    localparam logic [1:0] PAIR_FORCE_A = 2'h1;
    localparam logic [1:0] PAIR_FORCE_B = 2'h2;
    localparam logic [1:0] PAIR_FORCE_C = 2'h3;

    // ********************************************************************
    // Input clock numbers
    // ********************************************************************
    localparam logic [3:0] CLK_NONE = 4'h0;
    localparam logic [3:0] CLK_TWO = 4'h2;
    localparam logic [3:0] CLK_THREE = 4'h3;
    localparam logic [3:0] CLK_FOUR = 4'h4;
    localparam logic [3:0] CLK_FIVE = 4'h5;
    localparam logic [3:0] CLK_SIX = 4'h6;
    localparam logic [3:0] CLK_NINE = 4'h9;
    localparam logic [3:0] CLK_FIRST = 4'h1;
    localparam logic [3:0] CLK_LAST = 4'h9;
    localparam logic [3:0] CLK_LAST_LOW = 4'h4;

    // ********************************************************************
    // Encodings
    // ********************************************************************
    typedef enum logic [1:0] {
        PIN_A = 2'b00,
        PIN_B = 2'b01,
        PIN_C = 2'b10,
        PIN_NONE = 2'b11
    } pin_e;

    typedef enum logic [1:0] {
        RATE_NONE = 2'b00,
        RATE_2K = 2'b01,
        RATE_4K = 2'b10,
        RATE_8K = 2'b11
    } rate_e;

    typedef enum logic [3:0] {
        FREQ_8K = 4'h0,
        FREQ_19M44 = 4'h1,
        FREQ_2K = 4'h2,
        FREQ_4K = 4'h3,
        FREQ_1M544 = 4'h4,
        FREQ_2M048 = 4'h5,
        FREQ_6M48 = 4'h6,
        FREQ_38M88 = 4'h7,
        FREQ_NONE = 4'hf
    } freq_e;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SYNC_8K_PERIOD_NS = 125000;
    localparam int unsigned SYNC_4K_PERIOD_NS = 250000;
    localparam int unsigned SYNC_2K_PERIOD_NS = 500000;
    localparam int unsigned TOL_SHIFT = 3;
    localparam int unsigned CNT_W = 16;

endpackage : fsync_sel_pkg

`default_nettype wire

// ===== frame_sync_input_selector.sv
// Frame-sync input selector: pin routing, rate check, nominal defaults.
// Assumes pins and controls are synchronous to mclk.
`default_nettype none

// What this block does
// R1 - Outside pair scheme, pin a is the sync for the designated clock.
// R2 - Outside pair scheme, pins b and c are ignored.
// R3 - Pair scheme: pin a serves clock three or five.
// R4 - Pair scheme: pin b serves clock four or six.
// R5 - Pair scheme: pin c serves clock nine or two.
// R6 - Each sync pin accepts 2, 4 or 8 kHz.
// R7 - Clocks one to four reset to 8 kHz nominal.
// R8 - Clocks five, six, eight and nine reset to 19.44 MHz nominal.
// R9 - A 2 or 8 kHz sync may discipline the frame-sync outputs.
// R10 - Pair scheme when the top two source bits are both one.
module frame_sync_input_selector
    import fsync_sel_pkg::*;
#(
    parameter int unsigned PER_8K_CYCLES = SYNC_8K_PERIOD_NS / CLK_PERIOD_NS,
    parameter int unsigned PER_4K_CYCLES = SYNC_4K_PERIOD_NS / CLK_PERIOD_NS,
    parameter int unsigned PER_2K_CYCLES = SYNC_2K_PERIOD_NS / CLK_PERIOD_NS
)
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Frame-sync pins.
    input wire logic frame_sync_in_a,
    input wire logic frame_sync_in_b,
    input wire logic frame_sync_in_c,
    // Configuration.
    input wire logic [3:0] sync_source_select,
    input wire logic [1:0] sync_pair_select,
    input wire logic [3:0] selected_clock,
    // Nominal frequency table access.
    input wire logic freq_wr_en,
    input wire logic [3:0] freq_wr_index,
    input wire fsync_sel_pkg::freq_e freq_wr_code,
    input wire logic [3:0] freq_rd_index,
    // Results.
    output var logic ext_sync_r,
    output var logic ext_sync_edge_r,
    output var fsync_sel_pkg::pin_e sync_pin_r,
    output var logic [3:0] sync_assoc_clock_r,
    output var fsync_sel_pkg::rate_e sync_rate_r,
    output var logic discipline_en_r,
    output var fsync_sel_pkg::freq_e freq_rd_code_r
);
    import fsync_sel_pkg::*;

    // ********************************************************************
    // Rate windows
    // ********************************************************************
    localparam logic [CNT_W-1:0] LO_8K =
        CNT_W'(PER_8K_CYCLES - (PER_8K_CYCLES >> TOL_SHIFT));
    localparam logic [CNT_W-1:0] HI_8K =
        CNT_W'(PER_8K_CYCLES + (PER_8K_CYCLES >> TOL_SHIFT));
    localparam logic [CNT_W-1:0] LO_4K =
        CNT_W'(PER_4K_CYCLES - (PER_4K_CYCLES >> TOL_SHIFT));
    localparam logic [CNT_W-1:0] HI_4K =
        CNT_W'(PER_4K_CYCLES + (PER_4K_CYCLES >> TOL_SHIFT));
    localparam logic [CNT_W-1:0] LO_2K =
        CNT_W'(PER_2K_CYCLES - (PER_2K_CYCLES >> TOL_SHIFT));
    localparam logic [CNT_W-1:0] HI_2K =
        CNT_W'(PER_2K_CYCLES + (PER_2K_CYCLES >> TOL_SHIFT));
    // Slot seven has no input clock behind it.
    localparam logic [3:0] CLK_ABSENT = 4'h7;

    function automatic logic is_pair_mode(input logic [3:0] src);
        is_pair_mode = (src & SRC_PAIR_MASK) == SRC_PAIR_CODE;
    endfunction : is_pair_mode

    function automatic rate_e classify(input logic [CNT_W-1:0] per);
        if (per >= LO_8K && per <= HI_8K)
            classify = RATE_8K;
        else if (per >= LO_4K && per <= HI_4K)
            classify = RATE_4K;
        else if (per >= LO_2K && per <= HI_2K)
            classify = RATE_2K;
        else
            classify = RATE_NONE;
    endfunction : classify

    function automatic freq_e default_freq(input logic [3:0] idx);
        if (idx <= CLK_LAST_LOW)
            default_freq = FREQ_8K;
        else if (idx == CLK_ABSENT)
            default_freq = FREQ_NONE;
        else
            default_freq = FREQ_19M44;
    endfunction : default_freq

    logic [2:0] sync_q_r;
    pin_e pin_nxt;
    logic [3:0] assoc_nxt;
    logic sync_nxt;
    logic edge_w;
    logic pair_w;
    logic seen_r;
    logic [CNT_W-1:0] cnt_r;
    freq_e nominal_r [CLK_FIRST:CLK_LAST];

    // ********************************************************************
    // Pin routing
    // ********************************************************************

    // Pins are registered once so routing never sees a mid-cycle change.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            sync_q_r <= 3'h0;
        else
            sync_q_r <= {frame_sync_in_c, frame_sync_in_b, frame_sync_in_a};
    end

    // Choose the pin and the clock it is tied to.
    always_comb
    begin
        pair_w = is_pair_mode(sync_source_select); // R10
        pin_nxt = PIN_NONE;
        assoc_nxt = CLK_NONE;
        if (!pair_w)
        begin
            pin_nxt = PIN_A; // R1 R2
            assoc_nxt = sync_source_select; // R1
        end
        else if (sync_pair_select == PAIR_AUTO)
        begin
            assoc_nxt = selected_clock;
            unique case (selected_clock)
                CLK_THREE, CLK_FIVE: pin_nxt = PIN_A; // R3
                CLK_FOUR, CLK_SIX: pin_nxt = PIN_B; // R4
                CLK_NINE, CLK_TWO: pin_nxt = PIN_C; // R5
                default: assoc_nxt = CLK_NONE;
            endcase
        end
        else
        begin
            // A forced pin keeps the selected member, else its first one.
            unique case (sync_pair_select)
                PAIR_FORCE_A:
                begin
                    pin_nxt = PIN_A; // R3
                    assoc_nxt = (selected_clock == CLK_FIVE) ?
                        CLK_FIVE : CLK_THREE;
                end
                PAIR_FORCE_B:
                begin
                    pin_nxt = PIN_B; // R4
                    assoc_nxt = (selected_clock == CLK_SIX) ?
                        CLK_SIX : CLK_FOUR;
                end
                default:
                begin
                    pin_nxt = PIN_C; // R5
                    assoc_nxt = (selected_clock == CLK_TWO) ?
                        CLK_TWO : CLK_NINE;
                end
            endcase
        end
        unique case (pin_nxt)
            PIN_A: sync_nxt = sync_q_r[0];
            PIN_B: sync_nxt = sync_q_r[1];
            PIN_C: sync_nxt = sync_q_r[2];
            PIN_NONE: sync_nxt = 1'b0;
        endcase
        // An edge only counts when the route did not just change.
        edge_w = sync_nxt & ~ext_sync_r & (pin_nxt == sync_pin_r);
    end

    // Registered routing outputs.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ext_sync_r <= 1'b0;
            ext_sync_edge_r <= 1'b0;
            sync_pin_r <= PIN_NONE;
            sync_assoc_clock_r <= CLK_NONE;
        end
        else
        begin
            ext_sync_r <= sync_nxt;
            ext_sync_edge_r <= edge_w;
            sync_pin_r <= pin_nxt;
            sync_assoc_clock_r <= assoc_nxt;
        end
    end

    // ********************************************************************
    // Rate measurement
    // ********************************************************************

    // Period between rising edges; a route change restarts the measure.
    always_ff @(posedge mclk)
    begin
        if (!rst_n || pin_nxt != sync_pin_r)
        begin
            cnt_r <= '0;
            seen_r <= 1'b0;
            sync_rate_r <= RATE_NONE;
        end
        else if (edge_w)
        begin
            cnt_r <= '0;
            seen_r <= 1'b1;
            if (seen_r)
                sync_rate_r <= classify(cnt_r); // R6
        end
        else if (cnt_r >= HI_2K)
        begin
            // A silent pin is reported, not held at the last rate.
            seen_r <= 1'b0;
            sync_rate_r <= RATE_NONE;
        end
        else
            cnt_r <= cnt_r + CNT_W'(1);
    end

    // Only 2 kHz and 8 kHz may steer the frame-sync outputs.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            discipline_en_r <= 1'b0;
        else
            discipline_en_r <= (sync_rate_r == RATE_2K) ||
                (sync_rate_r == RATE_8K); // R9
    end

    // ********************************************************************
    // Nominal frequency table
    // ********************************************************************

    // Defaults return on every reset; slot seven has no input behind it.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            for (int i = CLK_FIRST; i <= CLK_LAST; i++)
                nominal_r[i] <= default_freq(4'(i)); // R7 R8
        end
        else if (freq_wr_en && freq_wr_index >= CLK_FIRST &&
            freq_wr_index <= CLK_LAST && freq_wr_index != CLK_ABSENT)
            nominal_r[freq_wr_index] <= freq_wr_code;
    end

    // Read port; out-of-range indexes read as no frequency.
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            freq_rd_code_r <= FREQ_NONE;
        else if (freq_rd_index >= CLK_FIRST && freq_rd_index <= CLK_LAST)
            freq_rd_code_r <= nominal_r[freq_rd_index];
        else
            freq_rd_code_r <= FREQ_NONE;
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_single_mode;
        !is_pair_mode(sync_source_select) |=> sync_pin_r == PIN_A &&
            sync_assoc_clock_r == $past(sync_source_select);
    endproperty
    a_single_mode: assert property (p_single_mode) // R1
        else $error("non-pair source did not route pin a");

    property p_ignore_bc;
        !is_pair_mode(sync_source_select) ##1
            !is_pair_mode(sync_source_select) |=>
            ext_sync_r == $past(sync_q_r[0]);
    endproperty
    a_ignore_bc: assert property (p_ignore_bc) // R2
        else $error("pins b or c reached the sync output");

    property p_pair_a;
        is_pair_mode(sync_source_select) && sync_pair_select == PAIR_AUTO &&
            (selected_clock == CLK_THREE || selected_clock == CLK_FIVE)
            |=> sync_pin_r == PIN_A && ext_sync_r == $past(sync_q_r[0]);
    endproperty
    a_pair_a: assert property (p_pair_a) // R3
        else $error("clock three or five not tied to pin a");

    property p_pair_b;
        is_pair_mode(sync_source_select) && sync_pair_select == PAIR_AUTO &&
            (selected_clock == CLK_FOUR || selected_clock == CLK_SIX)
            |=> sync_pin_r == PIN_B && ext_sync_r == $past(sync_q_r[1]);
    endproperty
    a_pair_b: assert property (p_pair_b) // R4
        else $error("clock four or six not tied to pin b");

    property p_pair_c;
        is_pair_mode(sync_source_select) && sync_pair_select == PAIR_AUTO &&
            (selected_clock == CLK_NINE || selected_clock == CLK_TWO)
            |=> sync_pin_r == PIN_C && ext_sync_r == $past(sync_q_r[2]);
    endproperty
    a_pair_c: assert property (p_pair_c) // R5
        else $error("clock nine or two not tied to pin c");

    property p_rate_8k;
        edge_w && seen_r && cnt_r >= LO_8K && cnt_r <= HI_8K
            |=> sync_rate_r == RATE_8K ##1 discipline_en_r;
    endproperty
    a_rate_8k: assert property (p_rate_8k) // R6
        else $error("8 kHz period not recognised");

    property p_disc_4k;
        sync_rate_r == RATE_4K |=> !discipline_en_r;
    endproperty
    a_disc_4k: assert property (p_disc_4k) // R9
        else $error("4 kHz sync enabled discipline");

    property p_reset_defaults;
        @(posedge mclk) disable iff (1'b0)
        !rst_n |=> nominal_r[1] == FREQ_8K && nominal_r[4] == FREQ_8K &&
            nominal_r[5] == FREQ_19M44 && nominal_r[9] == FREQ_19M44;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) // R7 R8
        else $error("nominal frequency defaults wrong after reset");

    property p_pair_decode;
        sync_source_select[3:2] == 2'b11 &&
            sync_pair_select == PAIR_FORCE_C |=> sync_pin_r == PIN_C;
    endproperty
    a_pair_decode: assert property (p_pair_decode) // R10
        else $error("11xx source did not enter pair scheme");

    c_pair_c_edge: cover property (sync_pin_r == PIN_C && ext_sync_edge_r);
    c_rate_8k: cover property (sync_rate_r == RATE_8K);
    c_rate_4k: cover property (sync_rate_r == RATE_4K);
    c_rate_2k: cover property (sync_rate_r == RATE_2K && discipline_en_r);

endmodule : frame_sync_input_selector

`default_nettype wire

// ===== fsync_source_model.sv
// Model of one upstream frame-sync source driving a sync pin.
// Assumes the bench changes run and period just after a clock edge.
`default_nettype none

module fsync_source_model (
    // Clock.
    input wire logic mclk,
    // Control from the bench.
    input wire logic run,
    input wire logic [15:0] period,
    input wire logic idle_level,
    // Sync pin.
    output var logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] cnt_r = 16'h0;

    // Square wave of the requested period while running; a stopped
    // source drives the pin to its idle_level input.
    always @(posedge mclk)
    begin
        if (!run)
        begin
            cnt_r <= 16'h0;
            pin <= #1 idle_level;
        end
        else
        begin
            cnt_r <= (cnt_r >= period - 16'h1) ? 16'h0 : cnt_r + 16'h1;
            pin <= #1 (cnt_r < (period >> 1));
        end
    end

endmodule : fsync_source_model

`default_nettype wire

// ===== test_frame_sync_input_selector.sv
// Self-checking bench for the frame-sync input selector.
// Assumes short sync periods of 40/80/160 cycles for the three rates.
`default_nettype none

module test_frame_sync_input_selector;
    import fsync_sel_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [1:0] kind; logic [6:0] val;} note_s;

    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic pin_a_tb = 1'b0;
    logic pin_b = 1'b0;
    logic pin_c = 1'b1;
    logic model_run = 1'b0;
    logic model_pin;
    logic [15:0] model_per = 16'd40;
    logic [3:0] src = 4'h1;
    logic [1:0] pair = 2'h0;
    logic [3:0] sel = 4'h1;
    logic wr_en = 1'b0;
    logic [3:0] wr_idx = 4'h0;
    freq_e wr_code = FREQ_8K;
    logic [3:0] rd_idx = 4'h0;
    logic ext_sync, ext_edge, disc;
    pin_e pin;
    logic [3:0] assoc;
    rate_e rate;
    freq_e rd_code;
    note_s notes[$];
    note_s cur;
    int miscompares = 0;
    int n_compared = 0;
    logic pin_a;

    // ****************************************************************
    // Clock, pins and instances
    // ****************************************************************
    always #12.5 mclk = ~mclk;

    // Pin a comes from the source model while it runs.
    assign pin_a = model_run ? model_pin : pin_a_tb;

    fsync_source_model src_model (.mclk(mclk), .run(model_run),
        .period(model_per), .idle_level(1'b0), .pin(model_pin));

    frame_sync_input_selector #(.PER_8K_CYCLES(40), .PER_4K_CYCLES(80),
        .PER_2K_CYCLES(160)) DUT (.mclk(mclk), .rst_n(rst_n),
        .frame_sync_in_a(pin_a), .frame_sync_in_b(pin_b),
        .frame_sync_in_c(pin_c), .sync_source_select(src),
        .sync_pair_select(pair), .selected_clock(sel),
        .freq_wr_en(wr_en), .freq_wr_index(wr_idx),
        .freq_wr_code(wr_code), .freq_rd_index(rd_idx),
        .ext_sync_r(ext_sync), .ext_sync_edge_r(ext_edge),
        .sync_pin_r(pin), .sync_assoc_clock_r(assoc),
        .sync_rate_r(rate), .discipline_en_r(disc),
        .freq_rd_code_r(rd_code));

    // ****************************************************************
    // Checking
    // ****************************************************************
    task automatic check(input logic [6:0] e, input logic [6:0] g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : check

    task automatic cmp_route(input logic [6:0] e);
        check(e, {pin, assoc, ext_sync});
    endtask : cmp_route

    task automatic cmp_rate(input logic [2:0] e);
        check({4'h0, e}, {4'h0, rate, disc});
    endtask : cmp_rate

    task automatic cmp_freq(input logic [3:0] e);
        check({3'h0, e}, {3'h0, rd_code});
    endtask : cmp_freq

    task automatic cmp_edge(input logic e);
        check({6'h0, e}, {6'h0, ext_edge});
    endtask : cmp_edge

    // Outputs are steady at the falling edge, so notes are settled there.
    always @(negedge mclk)
    begin
        while (notes.size() > 0)
        begin
            cur = notes.pop_front();
            case (cur.kind)
                2'h0: cmp_route(cur.val);
                2'h1: cmp_rate(cur.val[2:0]);
                2'h3: cmp_edge(cur.val[0]);
                default: cmp_freq(cur.val[3:0]);
            endcase
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // ****************************************************************
    // Stimulus helpers and expectations
    // ****************************************************************
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic note(input logic [1:0] k, input logic [6:0] v);
        notes.push_back({k, v});
    endtask : note

    function automatic logic [3:0] freq_exp(input int i);
        if (i >= 1 && i <= 4)
            return FREQ_8K;
        if (i == 5 || i == 6 || i == 8 || i == 9)
            return FREQ_19M44;
        return FREQ_NONE;
    endfunction : freq_exp

    // Packs the expected pin, clock and sync level of one route.
    function automatic logic [6:0] route_exp(input logic [3:0] s,
        input logic [1:0] p, input logic [3:0] c, input logic [2:0] lv);
        logic [1:0] mp;
        logic [1:0] fp;
        mp = (c == 4'h3 || c == 4'h5) ? 2'h0 :
             (c == 4'h4 || c == 4'h6) ? 2'h1 :
             (c == 4'h9 || c == 4'h2) ? 2'h2 : 2'h3;
        fp = p - 2'h1;
        if (s[3:2] != 2'b11)
            return {2'h0, s, lv[0]};
        if (p == 2'h0)
            return (mp == 2'h3) ? 7'h60 : {mp, c, lv[mp]};
        return {fp, (mp == fp) ? c : (fp == 2'h0) ? CLK_THREE :
            (fp == 2'h1) ? CLK_FOUR : CLK_NINE, lv[fp]};
    endfunction : route_exp

    task automatic wait_rate(input rate_e e);
        for (int i = 0; i < 1000 && rate !== e; i++)
            step(1);
        if (rate !== e)
        begin
            miscompares++;
            $display("ERROR t=%0t exp=%h got=%h", $time, e, rate);
            results();
        end
    endtask : wait_rate

    // A hang anywhere ends in the same closing report.
    initial
    begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        results();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [3:0] v;
        logic [15:0] pers[3];
        rate_e rx[3];
        pers = '{16'd40, 16'd80, 16'd160};
        rx = '{RATE_8K, RATE_4K, RATE_2K};
        void'($urandom(32'h926e6610));
        repeat (20) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        // Nominal defaults after reset, then reprogramming.
        for (int i = 0; i < 10; i++)
        begin
            rd_idx = i[3:0];
            step(2);
            note(2'h2, {3'h0, freq_exp(i)});
        end
        wr_idx = 4'h5;
        wr_code = FREQ_38M88;
        wr_en = 1'b1;
        step(1);
        wr_idx = 4'h7;
        wr_code = FREQ_2K;
        step(1);
        wr_en = 1'b0;
        rd_idx = 4'h5;
        step(2);
        note(2'h2, {3'h0, FREQ_38M88});
        rd_idx = 4'h7;
        step(2);
        note(2'h2, {3'h0, FREQ_NONE});
        // A reset mid-run restores the default over a rewritten slot.
        rst_n = 1'b0;
        rd_idx = 4'h5;
        step(2);
        rst_n = 1'b1;
        step(2);
        note(2'h2, {3'h0, FREQ_19M44});
        // Random routes across both schemes, pins held three edges.
        for (int i = 0; i < 80; i++)
        begin
            v = 4'($urandom_range(1, 13));
            src = (v > 4'h9) ? v + 4'h2 : v;
            pair = 2'($urandom_range(0, 3));
            sel = 4'($urandom_range(1, 9));
            {pin_c, pin_b, pin_a_tb} = 3'($urandom_range(0, 7));
            step(3);
            note(2'h0, route_exp(src, pair, sel,
                {pin_c, pin_b, pin_a_tb}));
        end
        // A rise on pin b under the pair scheme gives a one-cycle pulse.
        src = 4'hc;
        pair = 2'h0;
        sel = CLK_SIX;
        pin_b = 1'b0;
        step(3);
        pin_b = 1'b1;
        step(2);
        note(2'h3, 7'h01);
        step(1);
        note(2'h3, 7'h00);
        // Each sync rate on pin a, then loss of the source.
        src = CLK_THREE;
        pair = 2'h0;
        for (int k = 0; k < 3; k++)
        begin
            model_per = pers[k];
            model_run = 1'b1;
            wait_rate(rx[k]);
            step(2);
            note(2'h1, {4'h0, rx[k], rx[k] != RATE_4K});
            model_run = 1'b0;
            step(300);
            note(2'h1, {4'h0, RATE_NONE, 1'b0});
        end
        step(2);
        results();
    end

endmodule : test_frame_sync_input_selector

`default_nettype wire
